/* File: dma_irq_pkg.sv */
// package for the descriptor dma status and interrupt block
// assumes a 32-bit classic wishbone register bus with word addresses in bytes
package dma_irq_pkg;

  // --------------------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [7:0] status_offset = 8'h8C;
  localparam logic [7:0] enable_offset = 8'h90;
  localparam logic [7:0] pointer_offset = 8'h94;
  localparam logic [7:0] poll_offset = 8'h84;

  // --------------------------------------------------------------------------
  // status and enable bit positions
  // --------------------------------------------------------------------------
  localparam int tx_bit = 0;
  localparam int rx_bit = 1;
  localparam int fbe_bit = 2;
  localparam int du_bit = 4;
  localparam int ces_bit = 5;
  localparam int nis_bit = 8;
  localparam int ais_bit = 9;
  localparam int cause_lsb = 10;
  localparam int state_lsb = 13;

  // --------------------------------------------------------------------------
  // reset values and codes
  // --------------------------------------------------------------------------
  localparam logic [31:0] word_reset = 32'h0000_0000;
  localparam logic [2:0] cause_tx_abort = 3'h1;
  localparam logic [2:0] cause_rx_abort = 3'h2;
  localparam logic [2:0] cause_none = 3'h0;
  localparam int owner_bit = 31;

  typedef enum logic [3:0] {
    st_idle = 4'h0,
    st_suspend = 4'h1,
    st_desc_read = 4'h2,
    st_desc_check = 4'h3,
    st_rd_req_wait = 4'h4,
    st_wr_req_wait = 4'h5,
    st_read = 4'h6,
    st_write = 4'h7,
    st_state_descriptor_close = 4'h8
  } dma_state_type;

endpackage

/* File: dma_irq_status.sv */
// status, enables, summaries and interrupt of the descriptor dma engine
// assumes the dma datapath reports its state and events as same-clock pulses
//
// Functional notes
// - status shows dma state code 0..8 read-only
// - bus error cause: 1 transmit abort, 2 receive abort, read-only
// - cause field never drives the interrupt by itself
// - abnormal summary is OR of unmasked bus error and descriptor unavailable
// - normal summary is OR of unmasked transmit and receive complete
// - card error summary is OR of seven card errors, write one clears
// - response error aborts dma only while card error summary enabled
// - descriptor unavailable set when descriptor ownership bit is zero
// - bus error sets fatal flag and halts further dma bus accesses
// - receive complete set when one descriptor's reception finishes
// - transmit complete set when one descriptor's transmission finishes
// - source flags clear on write one, zero has no effect
// - abnormal enable gates bus error and descriptor unavailable sources
// - normal enable gates transmit and receive sources
// - card error summary enable allows its interrupt
// - source interrupts except card error summary need own enable and group enable
// - read-only descriptor pointer at 0x94, reset clears it
// - ownership clear suspends; any poll-demand write resumes fetch
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
module dma_irq_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] dma_state_i,
  input wire logic desc_fetched_i,
  input wire logic [31:0] desc_word0_i,
  input wire logic [31:0] desc_addr_i,
  input wire logic desc_addr_load_i,
  input wire logic bus_error_i,
  input wire logic bus_error_tx_i,
  input wire logic rx_done_i,
  input wire logic tx_done_i,
  input wire logic [6:0] card_errors_i,
  input wire logic response_error_i,
  output logic dma_abort_o,
  output logic bus_halt_o,
  output logic resume_o,
  output logic irq_o
);

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  logic req;
  logic wr;
  logic [3:0] state_q;
  logic [2:0] cause_q;
  logic [2:0] cause_d;
  logic tx_q;
  logic tx_d;
  logic rx_q;
  logic rx_d;
  logic fbe_q;
  logic fbe_d;
  logic du_q;
  logic du_d;
  logic ces_q;
  logic ces_d;
  logic nis_q;
  logic nis_d;
  logic ais_q;
  logic ais_d;
  logic [31:0] en_q;
  logic [31:0] en_d;
  logic [31:0] ptr_q;
  logic [31:0] ptr_d;
  logic halt_q;
  logic halt_d;
  logic abort_q;
  logic abort_d;
  logic resume_q;
  logic resume_d;
  logic irq_q;
  logic irq_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] w1c;
  logic du_event;

  function automatic logic hit(input logic [31:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]) && (adr[31:8] == 24'h00_0000);
  endfunction

  // byte lanes masked so partial writes only touch selected bytes
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;
  assign w1c = (wr && hit(wb_adr_i, dma_irq_pkg::status_offset)) ? (wb_dat_i & lane_mask(wb_sel_i))
                                                                  : dma_irq_pkg::word_reset;
  assign du_event = desc_fetched_i && !desc_word0_i[dma_irq_pkg::owner_bit];

  // --------------------------------------------------------------------------
  // flags, enables and pointer
  // --------------------------------------------------------------------------
  always_comb begin
    // set beats clear on the same edge so no event is lost
    tx_d = tx_done_i || (tx_q && !w1c[dma_irq_pkg::tx_bit]);
    rx_d = rx_done_i || (rx_q && !w1c[dma_irq_pkg::rx_bit]);
    fbe_d = bus_error_i || (fbe_q && !w1c[dma_irq_pkg::fbe_bit]);
    du_d = du_event || (du_q && !w1c[dma_irq_pkg::du_bit]);
    ces_d = (|card_errors_i) || (ces_q && !w1c[dma_irq_pkg::ces_bit]);
    // summaries stay sticky until written; software clears them with sources
    nis_d = (tx_d && en_q[dma_irq_pkg::tx_bit]) || (rx_d && en_q[dma_irq_pkg::rx_bit])
            || (nis_q && !w1c[dma_irq_pkg::nis_bit]);
    ais_d = (fbe_d && en_q[dma_irq_pkg::fbe_bit]) || (du_d && en_q[dma_irq_pkg::du_bit])
            || (ais_q && !w1c[dma_irq_pkg::ais_bit]);
    cause_d = cause_q;
    if (bus_error_i) begin
      cause_d = bus_error_tx_i ? dma_irq_pkg::cause_tx_abort : dma_irq_pkg::cause_rx_abort;
    end else if (!fbe_d) begin
      cause_d = dma_irq_pkg::cause_none;
    end
    en_d = en_q;
    if (wr && hit(wb_adr_i, dma_irq_pkg::enable_offset)) begin
      en_d = (en_q & ~lane_mask(wb_sel_i)) | (wb_dat_i & lane_mask(wb_sel_i));
    end
    ptr_d = desc_addr_load_i ? desc_addr_i : ptr_q;
    halt_d = fbe_d;
    abort_d = response_error_i && en_q[dma_irq_pkg::ces_bit];
    resume_d = wr && hit(wb_adr_i, dma_irq_pkg::poll_offset);
    // cause field is not a term here
    irq_d = (en_q[dma_irq_pkg::ais_bit] && ((fbe_d && en_q[dma_irq_pkg::fbe_bit])
              || (du_d && en_q[dma_irq_pkg::du_bit])))
            || (en_q[dma_irq_pkg::nis_bit] && ((tx_d && en_q[dma_irq_pkg::tx_bit])
              || (rx_d && en_q[dma_irq_pkg::rx_bit])))
            || (ces_d && en_q[dma_irq_pkg::ces_bit]);
    ack_d = req;
    rdata_d = dma_irq_pkg::word_reset;
    if (req && !wb_we_i) begin
      if (hit(wb_adr_i, dma_irq_pkg::status_offset)) begin
        rdata_d[dma_irq_pkg::tx_bit] = tx_q;
        rdata_d[dma_irq_pkg::rx_bit] = rx_q;
        rdata_d[dma_irq_pkg::fbe_bit] = fbe_q;
        rdata_d[dma_irq_pkg::du_bit] = du_q;
        rdata_d[dma_irq_pkg::ces_bit] = ces_q;
        rdata_d[dma_irq_pkg::nis_bit] = nis_q;
        rdata_d[dma_irq_pkg::ais_bit] = ais_q;
        rdata_d[dma_irq_pkg::cause_lsb +: 3] = cause_q;
        rdata_d[dma_irq_pkg::state_lsb +: 4] = state_q;
      end else if (hit(wb_adr_i, dma_irq_pkg::enable_offset)) begin
        rdata_d = en_q;
      end else if (hit(wb_adr_i, dma_irq_pkg::pointer_offset)) begin
        rdata_d = ptr_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= 4'h0;
      cause_q <= dma_irq_pkg::cause_none;
      tx_q <= 1'b0;
      rx_q <= 1'b0;
      fbe_q <= 1'b0;
      du_q <= 1'b0;
      ces_q <= 1'b0;
      nis_q <= 1'b0;
      ais_q <= 1'b0;
      en_q <= dma_irq_pkg::word_reset;
      ptr_q <= dma_irq_pkg::word_reset;
      halt_q <= 1'b0;
      abort_q <= 1'b0;
      resume_q <= 1'b0;
      irq_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= dma_irq_pkg::word_reset;
    end else begin
      state_q <= dma_state_i;
      cause_q <= cause_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      fbe_q <= fbe_d;
      du_q <= du_d;
      ces_q <= ces_d;
      nis_q <= nis_d;
      ais_q <= ais_d;
      en_q <= en_d;
      ptr_q <= ptr_d;
      halt_q <= halt_d;
      abort_q <= abort_d;
      resume_q <= resume_d;
      irq_q <= irq_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign dma_abort_o = abort_q;
  assign bus_halt_o = halt_q;
  assign resume_o = resume_q;
  assign irq_o = irq_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  tx_sets_a: assert property (@(posedge clk_i) disable iff (rst_i) tx_done_i |=> tx_q)
    else $error("transmit flag not set");
  rx_sets_a: assert property (@(posedge clk_i) disable iff (rst_i) rx_done_i |=> rx_q)
    else $error("receive flag not set");
  du_sets_a: assert property (@(posedge clk_i) disable iff (rst_i) du_event |=> du_q)
    else $error("descriptor unavailable not set");
  halt_follows_a: assert property (@(posedge clk_i) disable iff (rst_i) bus_error_i |=> bus_halt_o)
    else $error("bus not halted after error");
  fbe_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fbe_q && w1c[dma_irq_pkg::fbe_bit] && !bus_error_i) |=> !fbe_q)
    else $error("bus error flag not cleared");
  abort_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_abort_o |-> $past(response_error_i) && $past(en_q[dma_irq_pkg::ces_bit]))
    else $error("abort without enabled response error");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_q && en_q[dma_irq_pkg::tx_bit] && en_q[dma_irq_pkg::nis_bit] && $stable(en_q) && $stable(tx_q))
      |-> irq_o)
    else $error("enabled transmit did not interrupt");
  irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_q == 32'h0000_0000 && $past(en_q) == 32'h0000_0000) |-> !irq_o)
    else $error("interrupt with nothing enabled");
  nis_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_done_i && en_q[dma_irq_pkg::rx_bit]) |=> nis_q)
    else $error("normal summary not set");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  c_irq_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_du_c: cover property (@(posedge clk_i) disable iff (rst_i) du_event ##1 du_q);
  c_abort_c: cover property (@(posedge clk_i) disable iff (rst_i) response_error_i ##1 dma_abort_o);
  c_resume_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(resume_o));

  // --------------------------------------------------------------------------
  // status fields and summaries
  // --------------------------------------------------------------------------
  state_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (state_q == $past(dma_state_i)))
    else $error("state code not reported");
  cause_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_error_i && bus_error_tx_i) |=> (cause_q == dma_irq_pkg::cause_tx_abort))
    else $error("transmit abort cause wrong");
  cause_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_error_i && !bus_error_tx_i) |=> (cause_q == dma_irq_pkg::cause_rx_abort))
    else $error("receive abort cause wrong");
  cause_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fbe_q |-> (cause_q == dma_irq_pkg::cause_none))
    else $error("cause shown without bus error");
  cause_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(en_q[dma_irq_pkg::fbe_bit]) && !$past(en_q[dma_irq_pkg::du_bit]) && !$past(en_q[dma_irq_pkg::nis_bit])
      && !$past(en_q[dma_irq_pkg::ces_bit])) |-> !irq_o)
    else $error("interrupt from cause field");
  ais_fbe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_error_i && en_q[dma_irq_pkg::fbe_bit]) |=> ais_q)
    else $error("abnormal summary missed bus error");
  ais_du_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (du_event && en_q[dma_irq_pkg::du_bit]) |=> ais_q)
    else $error("abnormal summary missed unavailable");
  ais_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ais_q && !(fbe_d && en_q[dma_irq_pkg::fbe_bit]) && !(du_d && en_q[dma_irq_pkg::du_bit])) |=> !ais_q)
    else $error("abnormal summary from masked source");
  nis_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_done_i && en_q[dma_irq_pkg::tx_bit]) |=> nis_q)
    else $error("normal summary missed transmit");
  nis_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!nis_q && !(tx_d && en_q[dma_irq_pkg::tx_bit]) && !(rx_d && en_q[dma_irq_pkg::rx_bit])) |=> !nis_q)
    else $error("normal summary from masked source");
  nis_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (nis_q && !w1c[dma_irq_pkg::nis_bit]) |=> nis_q)
    else $error("normal summary cleared itself");
  ais_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ais_q && !w1c[dma_irq_pkg::ais_bit]) |=> ais_q)
    else $error("abnormal summary cleared itself");
  ces_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|card_errors_i) |=> ces_q)
    else $error("card summary not set");
  ces_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ces_q && w1c[dma_irq_pkg::ces_bit] && !(|card_errors_i)) |=> !ces_q)
    else $error("card summary not cleared");

  // --------------------------------------------------------------------------
  // dma control outputs and source flags
  // --------------------------------------------------------------------------
  abort_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (response_error_i && en_q[dma_irq_pkg::ces_bit]) |=> dma_abort_o)
    else $error("no abort on enabled response error");
  abort_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_q[dma_irq_pkg::ces_bit] |=> !dma_abort_o)
    else $error("abort while card summary disabled");
  du_owned_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!du_q && !du_event) |=> !du_q)
    else $error("unavailable set for owned descriptor");
  fbe_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_error_i |=> fbe_q)
    else $error("fatal bus error flag not set");
  halt_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> (bus_halt_o == fbe_q))
    else $error("bus halt differs from fatal flag");
  tx_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_q && w1c[dma_irq_pkg::tx_bit] && !tx_done_i) |=> !tx_q)
    else $error("transmit flag not cleared");
  rx_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_q && w1c[dma_irq_pkg::rx_bit] && !rx_done_i) |=> !rx_q)
    else $error("receive flag not cleared");
  du_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (du_q && w1c[dma_irq_pkg::du_bit] && !du_event) |=> !du_q)
    else $error("unavailable flag not cleared");
  tx_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_q && !w1c[dma_irq_pkg::tx_bit]) |=> tx_q)
    else $error("transmit flag lost without write");

  // --------------------------------------------------------------------------
  // interrupt, pointer and bus
  // --------------------------------------------------------------------------
  abn_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fbe_q && en_q[dma_irq_pkg::fbe_bit] && en_q[dma_irq_pkg::ais_bit] && $stable(en_q)) |-> irq_o)
    else $error("enabled bus error did not interrupt");
  du_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (du_q && en_q[dma_irq_pkg::du_bit] && en_q[dma_irq_pkg::ais_bit] && $stable(en_q)) |-> irq_o)
    else $error("enabled unavailable did not interrupt");
  rx_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_q && en_q[dma_irq_pkg::rx_bit] && en_q[dma_irq_pkg::nis_bit] && $stable(en_q)) |-> irq_o)
    else $error("enabled receive did not interrupt");
  en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(wb_adr_i, dma_irq_pkg::enable_offset) && wb_sel_i == 4'hF) |=> (en_q == $past(wb_dat_i)))
    else $error("enable write lost");
  ces_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ces_q && en_q[dma_irq_pkg::ces_bit] && $stable(en_q)) |-> irq_o)
    else $error("enabled card summary did not interrupt");
  group_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(en_q[dma_irq_pkg::ais_bit]) && !$past(en_q[dma_irq_pkg::nis_bit]) && !$past(en_q[dma_irq_pkg::ces_bit]))
      |-> !irq_o)
    else $error("interrupt with groups disabled");
  ptr_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    desc_addr_load_i |=> (ptr_q == $past(desc_addr_i)))
    else $error("descriptor pointer not loaded");
  ptr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !desc_addr_load_i |=> $stable(ptr_q))
    else $error("descriptor pointer changed");
  resume_poll_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(wb_adr_i, dma_irq_pkg::poll_offset)) |=> resume_o)
    else $error("poll demand did not resume");
  resume_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    resume_o |=> !resume_o)
    else $error("resume longer than one cycle");
  irq_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(!tx_d && !rx_d && !fbe_d && !du_d && !ces_d) |-> !irq_o)
    else $error("interrupt with no flag set");
  ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not acknowledged");
  rdata_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data outside ack");
  c_fbe_c: cover property (@(posedge clk_i) disable iff (rst_i) bus_error_i ##[1:20] !fbe_q);

endmodule // dma_irq_status

/* File: tb_card_host_dma_irq_status.sv */
// self-checking bench for the dma status and interrupt block
// assumes the design package is compiled first; the bench drives every port itself
`timescale 1ns/1ns
module tb_card_host_dma_irq_status;
  // ----------------------------------------
  // signals and table
  // ----------------------------------------
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, desc_word0_i, desc_addr_i, rd;
  logic [3:0] wb_sel_i, dma_state_i;
  logic desc_fetched_i, desc_addr_load_i, bus_error_i, bus_error_tx_i, rx_done_i, tx_done_i;
  logic response_error_i, dma_abort_o, bus_halt_o, resume_o, irq_o;
  logic [6:0] card_errors_i;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int resumes = 0;
  int n0;
  typedef struct {logic [9:0] en; logic [4:0] ev; logic [12:0] stat; logic irq;} row_type;
  // event bits: 0 tx, 1 rx, 2 bus error, 3 unowned descriptor, 4 card error
  row_type rows [9] = '{'{10'h103, 5'h01, 13'h0101, 1'b1}, '{10'h003, 5'h02, 13'h0102, 1'b0},
    '{10'h100, 5'h01, 13'h0001, 1'b0}, '{10'h204, 5'h04, 13'h0604, 1'b1}, '{10'h210, 5'h08, 13'h0210, 1'b1},
    '{10'h010, 5'h08, 13'h0210, 1'b0}, '{10'h020, 5'h10, 13'h0020, 1'b1}, '{10'h000, 5'h10, 13'h0020, 1'b0},
    '{10'h337, 5'h1F, 13'h0737, 1'b1}};

  dma_irq_status u_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .dma_state_i, .desc_fetched_i, .desc_word0_i, .desc_addr_i, .desc_addr_load_i,
    .bus_error_i, .bus_error_tx_i, .rx_done_i, .tx_done_i, .card_errors_i, .response_error_i,
    .dma_abort_o, .bus_halt_o, .resume_o, .irq_o);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // request held until ack is sampled high, released at that same edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {24'h00_0000, adr};
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk("ack", {31'h0000_0000, wb_ack_o}, 32'h0000_0001);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic st_rd();
    wb(1'b0, dma_irq_pkg::status_offset, 32'h0000_0000);
  endtask

  task automatic st_wr(input logic [31:0] d);
    wb(1'b1, dma_irq_pkg::status_offset, d);
  endtask

  task automatic en_wr(input logic [31:0] d);
    wb(1'b1, dma_irq_pkg::enable_offset, d);
  endtask

  // one-cycle event pulses, then time for flag and interrupt to settle
  task automatic fire(input logic [4:0] ev, input logic [6:0] card);
    @(posedge clk_i);
    {card_errors_i, desc_fetched_i, bus_error_i, rx_done_i, tx_done_i} <= {card, ev[3:0]};
    @(posedge clk_i);
    {card_errors_i, desc_fetched_i, bus_error_i, rx_done_i, tx_done_i} <= 11'h000;
    repeat (3) @(posedge clk_i);
  endtask

  // ----------------------------------------
  // clock, cycle limit, main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // a run that never reaches end_of_test is cut here at 20000 cycles instead of running forever
  always @(posedge clk_i) begin
    cycles++;
    if (resume_o === 1'b1) resumes++;
    if (cycles == 20000) begin
      chk("cycle_limit", 32'h0000_0001, 32'h0000_0000);
      end_of_test();
    end
  end

  initial begin
    {rst_i, bus_error_tx_i} = 2'b11;
    {wb_we_i, wb_cyc_i, wb_stb_i, desc_fetched_i, desc_addr_load_i, bus_error_i} = 6'h00;
    {rx_done_i, tx_done_i, response_error_i, card_errors_i} = 10'h000;
    {wb_adr_i, wb_dat_i, desc_word0_i, desc_addr_i} = 128'h0;
    {wb_sel_i, dma_state_i} = 8'hF0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    st_rd();
    chk("status_reset", rd, 32'h0000_0000);
    wb(1'b0, dma_irq_pkg::enable_offset, 32'h0000_0000);
    chk("enable_reset", rd, 32'h0000_0000);
    chk("irq_reset", irq_o, 32'h0000_0000);
    foreach (rows[i]) begin
      en_wr({22'h00_0000, rows[i].en});
      fire(rows[i].ev, {6'h00, rows[i].ev[4]});
      chk("irq", irq_o, rows[i].irq);
      st_rd();
      chk("status", rd & 32'h0000_1FFF, rows[i].stat);
      st_wr(32'h0000_0337);
      st_rd();
      chk("cleared", rd, 32'h0000_0000);
      $display("row %0d done", i);
    end
    // writing zero must leave flags alone; the summary outlives its source
    en_wr(32'h0000_0101);
    fire(5'h01, 7'h00);
    st_wr(32'h0000_0000);
    st_wr(32'h0000_0001);
    st_rd();
    chk("sticky", rd[12:0], 32'h0000_0100);
    st_wr(32'h0000_0337);
    en_wr(32'h0000_0000);
    bus_error_tx_i <= 1'b0;
    fire(5'h04, 7'h00);
    chk("halt", bus_halt_o, 32'h0000_0001);
    chk("cause_irq", irq_o, 32'h0000_0000);
    st_rd();
    chk("cause", rd[12:10], 32'h0000_0002);
    st_wr(32'h0000_0337);
    desc_word0_i <= 32'h8000_0000;
    fire(5'h08, 7'h00);
    st_rd();
    chk("owned", rd[4], 32'h0000_0000);
    for (int k = 0; k < 7; k++) begin
      fire(5'h00, 7'h01 << k);
      st_rd();
      chk("card", rd[5], 32'h0000_0001);
      st_wr(32'h0000_0020);
    end
    $display("flag tests done");
    for (int k = 0; k < 2; k++) begin
      en_wr(k == 0 ? 32'h0000_0020 : 32'h0000_0000);
      @(posedge clk_i);
      response_error_i <= 1'b1;
      @(posedge clk_i);
      response_error_i <= 1'b0;
      #1 chk("abort", dma_abort_o, (k == 0) ? 32'h0000_0001 : 32'h0000_0000);
    end
    for (int s = 0; s < 9; s++) begin
      dma_state_i <= s[3:0];
      @(posedge clk_i);
      st_rd();
      chk("state", rd[16:13], s);
    end
    @(posedge clk_i);
    desc_addr_i <= 32'h1234_5678;
    desc_addr_load_i <= 1'b1;
    @(posedge clk_i);
    desc_addr_load_i <= 1'b0;
    wb(1'b1, dma_irq_pkg::pointer_offset, 32'h0000_0000);
    wb(1'b0, dma_irq_pkg::pointer_offset, 32'h0000_0000);
    chk("pointer", rd, 32'h1234_5678);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    n0 = resumes;
    wb(1'b1, dma_irq_pkg::poll_offset, 32'hA5A5_A5A5);
    repeat (3) @(posedge clk_i);
    chk("resume", resumes - n0, 32'h0000_0001);
    $display("control tests done");
    // a reset in mid-run must clear enables, flags, interrupt and pointer
    en_wr(32'h0000_0337);
    fire(5'h01, 7'h00);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("irq_rst", irq_o, 32'h0000_0000);
    wb(1'b0, dma_irq_pkg::enable_offset, 32'h0000_0000);
    chk("enable_rst", rd, 32'h0000_0000);
    wb(1'b0, dma_irq_pkg::pointer_offset, 32'h0000_0000);
    chk("pointer_rst", rd, 32'h0000_0000);
    st_rd();
    chk("status_rst", rd[12:0], 32'h0000_0000);
    $display("reset tests done");
    end_of_test();
  end
endmodule // tb_card_host_dma_irq_status
